// ===== digipot_pkg.sv
/*
  Shared constants and carrier types for the two-wire digital potentiometer control block.
  Assumes nothing of its surroundings; every design file refers to it by package::name.
*/
package digipot_pkg;
  localparam logic [4:0] ADDR_FIXED = 5'h0b;
  localparam int INSTR_CHAN_BIT = 7;
  localparam int INSTR_MID_BIT = 6;
  localparam int INSTR_SHUTDOWN_PIN_N_BIT = 5;
  localparam int INSTR_OUT2_BIT = 4;
  localparam int INSTR_OUT1_BIT = 3;
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam logic [7:0] WIPER_MID = 8'h80;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_INSTR,
    ST_DATA,
    ST_READ,
    ST_SKIP
  } link_state_t;

  typedef struct packed {
    logic [7:0] wiperA;
    logic [7:0] wiperB;
    logic outFirst;
    logic outSecond;
    logic shdnBit;
  } pot_state_t;
endpackage

// ===== digipot_serial_control.sv
/*
  Two-wire serial slave for a one- or two-channel 256-position digital potentiometer.
  Assumes SCL is the link clock, SDA arrives as a plain input and is driven through an enable
  that is low while driving; the core clock side sees the settings through a level crossing.
*/
// Function
// - A read on the dual variant returns the code of the channel last selected by a write.
// - A read may follow a repeated start right after address and instruction bytes.
// - The device answers only when the two low address bits match its strap pins.
// - Both logic outputs are low after power-up until programmed.
// - Both logic outputs take their bits from the instruction byte of a write.
// - A write with no data byte changes the logic outputs and no wiper code.
// - A new start during an open write begins a fresh update that ends with a stop.
// - Shutdown follows the active-low pin or the stored shutdown bit.
// - Serial writes are accepted while in shutdown.
// - Leaving shutdown applies the most recently programmed wiper code.
// - The slave address is 01011 followed by the two strap bits and a read/write bit.
// - Instruction bits from the top are channel, midscale reset, shutdown, out2, out1.
// - A read drives the eight-bit code right after the address acknowledge.
// - Each further data byte in a write updates the selected channel with that instruction.
`timescale 1ns/1ps
module digipot_serial_control #(
  parameter bit DUAL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  input wire logic addrStrapLow,
  input wire logic addrStrapHigh,
  input wire logic shutdownPin_n,
  output logic logicOutFirst,
  output logic logicOutSecond,
  output logic shutdownActive,
  output logic [7:0] wiperFirst,
  output logic [7:0] wiperSecond
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release on the core clock; the link side uses the raw asynchronous reset.
  logic rstMeta_r, rstSync_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // SCL stands still between frames, so the link side holds the raw asynchronous reset.
  // Reset is applied at power-up, which is when the outputs must be low.
  wire linkRst_n = rst_n;

  ////////////////////////////////////////////////////////////////////////////
  // Start and stop detection: SDA edges while SCL is high.
  logic startTog_r, stopTog_r;
  always_ff @(negedge sdaIn or negedge linkRst_n) begin
    if (!linkRst_n) begin
      startTog_r <= 1'b0;
    end else if (scl) begin
      startTog_r <= ~startTog_r;
    end
  end
  always_ff @(posedge sdaIn or negedge linkRst_n) begin
    if (!linkRst_n) begin
      stopTog_r <= 1'b0;
    end else if (scl) begin
      stopTog_r <= ~stopTog_r;
    end
  end

  // The link logic compares the toggles with copies it made, so a start or stop is seen
  // at the next SCL rising edge; a stop only ends the frame, so that lag is harmless.
  logic startSeen_r, stopSeen_r;
  wire startPend = startTog_r ^ startSeen_r;
  wire stopPend = stopTog_r ^ stopSeen_r;

  ////////////////////////////////////////////////////////////////////////////
  // Link state, clocked on SCL rising edges.
  digipot_pkg::link_state_t state_r, state_nxt;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r;
  logic [7:0] instr_r;
  logic isRead_r;
  logic chanSel_r;
  digipot_pkg::pot_state_t pot_r;

  wire [7:0] rxByte = {shift_r[6:0], sdaIn};
  wire byteDone = (bitCnt_r == digipot_pkg::LAST_BIT);
  wire ackSlot = (bitCnt_r == digipot_pkg::ACK_BIT);
  wire addrMatch = (rxByte[7:3] == digipot_pkg::ADDR_FIXED) &&
                   (rxByte[2] == addrStrapHigh) && (rxByte[1] == addrStrapLow);
  wire instrChan = DUAL ? rxByte[digipot_pkg::INSTR_CHAN_BIT] : 1'b0;
  wire [7:0] readCode = chanSel_r ? pot_r.wiperB : pot_r.wiperA;
  wire [7:0] dataCode = instr_r[digipot_pkg::INSTR_MID_BIT] ? digipot_pkg::WIPER_MID : rxByte;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      digipot_pkg::ST_IDLE: state_nxt = state_r;
      digipot_pkg::ST_ADDR: begin
        if (ackSlot) begin
          state_nxt = isRead_r ? digipot_pkg::ST_READ : digipot_pkg::ST_INSTR;
        end
      end
      digipot_pkg::ST_INSTR: begin
        if (ackSlot) begin
          state_nxt = digipot_pkg::ST_DATA;
        end
      end
      digipot_pkg::ST_DATA: state_nxt = state_r;
      digipot_pkg::ST_READ: begin
        if (ackSlot && sdaIn) begin
          state_nxt = digipot_pkg::ST_SKIP;
        end
      end
      digipot_pkg::ST_SKIP: state_nxt = state_r;
      default: state_nxt = digipot_pkg::ST_IDLE;
    endcase
    if (state_r == digipot_pkg::ST_ADDR && byteDone && !addrMatch) begin
      state_nxt = digipot_pkg::ST_SKIP;
    end
    if (stopPend) begin
      state_nxt = digipot_pkg::ST_IDLE;
    end
    if (startPend) begin
      state_nxt = digipot_pkg::ST_ADDR;
    end
  end

  always_ff @(posedge scl or negedge linkRst_n) begin
    if (!linkRst_n) begin
      state_r <= digipot_pkg::ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      startSeen_r <= 1'b0;
      stopSeen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      startSeen_r <= startTog_r;
      stopSeen_r <= stopTog_r;
      // The start rise already carries the first address bit, so the count resumes at one.
      bitCnt_r <= startPend ? 4'h1 : (ackSlot ? 4'h0 : bitCnt_r + 4'h1);
      shift_r <= rxByte;
    end
  end

  // The start edge usually precedes the first SCL rise, so its first bit is the address MSB.
  always_ff @(posedge scl or negedge linkRst_n) begin
    if (!linkRst_n) begin
      isRead_r <= 1'b0;
      instr_r <= 8'h00;
      chanSel_r <= 1'b0;
      pot_r <= '{digipot_pkg::WIPER_RESET, digipot_pkg::WIPER_RESET, 1'b0, 1'b0, 1'b0};
    end else begin
      if (state_nxt == digipot_pkg::ST_ADDR && byteDone) begin
        isRead_r <= rxByte[0];
      end
      // Writes are taken regardless of shutdown; shutdown only gates the analog side.
      if (state_r == digipot_pkg::ST_INSTR && byteDone && !startPend) begin
        instr_r <= rxByte;
        chanSel_r <= instrChan;
        pot_r.outFirst <= rxByte[digipot_pkg::INSTR_OUT1_BIT];
        pot_r.outSecond <= rxByte[digipot_pkg::INSTR_OUT2_BIT];
        pot_r.shdnBit <= rxByte[digipot_pkg::INSTR_SHUTDOWN_PIN_N_BIT];
      end
      if (state_r == digipot_pkg::ST_DATA && byteDone && !startPend) begin
        if (chanSel_r) begin
          pot_r.wiperB <= dataCode;
        end else begin
          pot_r.wiperA <= dataCode;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SDA drive, changed on SCL falling edges so it is stable while SCL is high.
  logic [7:0] txShift_r;
  logic drive_r;
  always_ff @(negedge scl or negedge linkRst_n) begin
    if (!linkRst_n) begin
      drive_r <= 1'b0;
      txShift_r <= 8'h00;
    end else if (state_r == digipot_pkg::ST_READ && bitCnt_r == 4'h0) begin
      txShift_r <= {readCode[6:0], 1'b0};
      drive_r <= ~readCode[7];
    end else if (state_r == digipot_pkg::ST_READ && bitCnt_r < digipot_pkg::ACK_BIT) begin
      txShift_r <= {txShift_r[6:0], 1'b0};
      drive_r <= ~txShift_r[7];
    end else begin
      drive_r <= (bitCnt_r == digipot_pkg::ACK_BIT) && (state_r != digipot_pkg::ST_READ) &&
                 (state_r != digipot_pkg::ST_SKIP) && (state_r != digipot_pkg::ST_IDLE);
    end
  end
  assign sdaOut = 1'b0;
  assign sdaOe_n = ~drive_r;

  ////////////////////////////////////////////////////////////////////////////
  // Settings cross to the core clock as slow levels; the pin is synchronised likewise.
  digipot_pkg::pot_state_t potMeta_r, potSync_r, potHold_r, potOut_r;
  logic pinMeta_r, pinSync_r, shutdown_pin_n_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      potMeta_r <= '{digipot_pkg::WIPER_RESET, digipot_pkg::WIPER_RESET, 1'b0, 1'b0, 1'b0};
      potSync_r <= '{digipot_pkg::WIPER_RESET, digipot_pkg::WIPER_RESET, 1'b0, 1'b0, 1'b0};
      potHold_r <= '{digipot_pkg::WIPER_RESET, digipot_pkg::WIPER_RESET, 1'b0, 1'b0, 1'b0};
      potOut_r <= '{digipot_pkg::WIPER_RESET, digipot_pkg::WIPER_RESET, 1'b0, 1'b0, 1'b0};
      pinMeta_r <= 1'b1;
      pinSync_r <= 1'b1;
      shutdown_pin_n_r <= 1'b0;
    end else begin
      potMeta_r <= pot_r;
      potSync_r <= potMeta_r;
      potHold_r <= potSync_r;
      // A word is only taken when two samples agree, so a torn multi-bit copy never shows.
      if (potSync_r == potHold_r) begin
        potOut_r <= potSync_r;
      end
      pinMeta_r <= shutdownPin_n;
      pinSync_r <= pinMeta_r;
      shutdown_pin_n_r <= ~pinSync_r | potSync_r.shdnBit;
    end
  end
  // Wiper codes pass unchanged through shutdown; the analog stage uses shutdownActive.
  assign wiperFirst = potOut_r.wiperA;
  assign wiperSecond = potOut_r.wiperB;
  assign logicOutFirst = potOut_r.outFirst;
  assign logicOutSecond = potOut_r.outSecond;
  assign shutdownActive = shutdown_pin_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  out_low_a: assert property (@(posedge core_clk) disable iff (!rstSync_r)
    !$past(rstSync_r) |-> !logicOutFirst && !logicOutSecond)
    else $error("logic outputs not low after reset");
  pin_shutdown_pin_n_a: assert property (@(posedge core_clk) disable iff (!rstSync_r)
    $fell(pinSync_r) |=> shutdownActive)
    else $error("pin shutdown not applied");
  shutdown_pin_n_or_a: assert property (@(posedge core_clk) disable iff (!rstSync_r)
    shutdownActive == $past(~pinSync_r | potSync_r.shdnBit))
    else $error("shutdown is not pin or bit");
  keep_wiper_a: assert property (@(posedge core_clk) disable iff (!rstSync_r)
    $stable(potSync_r) && $stable(potHold_r) |=> $stable(wiperFirst))
    else $error("wiper changed without write");
  no_data_a: assert property (@(posedge scl) disable iff (!linkRst_n)
    state_r == digipot_pkg::ST_INSTR |=> $stable(pot_r.wiperA) && $stable(pot_r.wiperB))
    else $error("instruction byte changed wiper");
  addr_nak_a: assert property (@(posedge scl) disable iff (!linkRst_n)
    state_r == digipot_pkg::ST_ADDR && byteDone && !addrMatch && !startPend && !stopPend
    |=> state_r == digipot_pkg::ST_SKIP)
    else $error("foreign address accepted");
  start_any_a: assert property (@(posedge scl) disable iff (!linkRst_n)
    startPend |=> state_r == digipot_pkg::ST_ADDR && bitCnt_r == 4'h1)
    else $error("start not taken");
  read_go_a: assert property (@(posedge scl) disable iff (!linkRst_n)
    state_r == digipot_pkg::ST_ADDR && ackSlot && isRead_r && !startPend && !stopPend
    |=> state_r == digipot_pkg::ST_READ)
    else $error("read not entered");
  chan_keep_a: assert property (@(posedge scl) disable iff (!linkRst_n)
    state_r == digipot_pkg::ST_READ |-> $stable(chanSel_r))
    else $error("channel changed during read");
  addr_ack_a: assert property (@(posedge scl) disable iff (!linkRst_n)
    state_r == digipot_pkg::ST_ADDR && byteDone && addrMatch && !startPend && !stopPend
    |=> !sdaOe_n)
    else $error("own address not acknowledged");
  skip_quiet_a: assert property (@(posedge scl) disable iff (!linkRst_n)
    state_r == digipot_pkg::ST_SKIP |-> sdaOe_n ##1 $stable(pot_r))
    else $error("skipped frame drove the bus or a setting");
  instr_out_a: assert property (@(posedge scl) disable iff (!linkRst_n)
    state_r == digipot_pkg::ST_INSTR && byteDone && !startPend
    |=> pot_r.outFirst == $past(rxByte[digipot_pkg::INSTR_OUT1_BIT]) &&
        pot_r.outSecond == $past(rxByte[digipot_pkg::INSTR_OUT2_BIT]))
    else $error("logic outputs not taken from instruction");
  data_write_a: assert property (@(posedge scl) disable iff (!linkRst_n)
    state_r == digipot_pkg::ST_DATA && byteDone && !startPend && !chanSel_r &&
    !instr_r[digipot_pkg::INSTR_MID_BIT] |=> pot_r.wiperA == $past(rxByte))
    else $error("data byte not written to first channel");
  mid_write_a: assert property (@(posedge scl) disable iff (!linkRst_n)
    state_r == digipot_pkg::ST_DATA && byteDone && !startPend && chanSel_r &&
    instr_r[digipot_pkg::INSTR_MID_BIT] |=> pot_r.wiperB == digipot_pkg::WIPER_MID)
    else $error("midscale reset not applied");
  read_nak_a: assert property (@(posedge scl) disable iff (!linkRst_n)
    state_r == digipot_pkg::ST_READ && ackSlot && sdaIn && !startPend && !stopPend
    |=> state_r == digipot_pkg::ST_SKIP)
    else $error("read not ended by master release");
  instr_ack_a: assert property (@(posedge scl) disable iff (!linkRst_n)
    state_r == digipot_pkg::ST_INSTR && byteDone && !startPend && !stopPend |=> !sdaOe_n)
    else $error("instruction byte not acknowledged");
  cov_read_c: cover property (@(posedge scl) state_r == digipot_pkg::ST_READ);
  cov_data_c: cover property (@(posedge scl) state_r == digipot_pkg::ST_DATA && byteDone);
  cov_shutdown_pin_n_c: cover property (@(posedge core_clk) $rose(shutdownActive));
  cov_skip_c: cover property (@(posedge scl) state_r == digipot_pkg::ST_SKIP && !isRead_r);
  cov_wake_c: cover property (@(posedge core_clk) $fell(shutdownActive) && pinSync_r);
endmodule

// ===== digipot_master_model.sv
/*
  Behavioural two-wire bus master that drives the potentiometer control block.
  Assumes a pull-up on SDA, so driving a one means letting the line go.
*/
`timescale 1ns/1ps
module digipot_master_model (
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaLine
);
  ////////////////////////////////////////
  // SCL stands high between frames and only toggles inside them.
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic start();
    sdaDrv = 1'b1;
    #40 scl = 1'b1;
    #40 sdaDrv = 1'b0;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic stop();
    sdaDrv = 1'b0;
    #40 scl = 1'b1;
    #40 sdaDrv = 1'b1;
    #80;
  endtask
  // Nine clocks: eight bits, then the acknowledge slot, where lastBit high is a release or NAK.
  task automatic byte_io(input logic [7:0] txb, input logic lastBit, output logic [7:0] rxb,
                         output logic ack);
    logic [8:0] frame;
    logic [8:0] seen;
    frame = {txb, lastBit};
    for (int i = 8; i >= 0; i--) begin
      sdaDrv = frame[i];
      #40 scl = 1'b1;
      #40 seen[i] = sdaLine;
      #40 scl = 1'b0;
      #40;
    end
    rxb = seen[8:1];
    ack = ~seen[0];
  endtask
endmodule

// ===== digipot_serial_control_tb.sv
/*
  Self-checking bench for the two-wire potentiometer control block.
  Assumes the package and the master model are compiled before it.
*/
`timescale 1ns/1ps
module digipot_serial_control_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic strapLo, strapHi, selfMode;
  wire logic scl, sdaDrv, sdaLine, sdaOut, sdaOe_n, outA, outB, shutdown_pin_n;
  wire logic [7:0] wipA, wipB;
  wire logic [7:0] outs = {6'h00, outB, outA};
  int mismatches = 0;
  int n_checks = 0;
  int seed = 5;
  logic [31:0] rnd;
  logic [7:0] expQ[$];
  logic [7:0] obs, head, rx, aW, aR, d0, d1, d2;
  logic ack;
  event got;
  always #5 core_clk = ~core_clk;
  assign sdaLine = sdaDrv & (sdaOe_n | sdaOut);
  digipot_master_model bm (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));
  // In self mode the first logic output drives the shutdown pin.
  digipot_serial_control #(.DUAL(1'b1)) dut (.core_clk(core_clk), .rst_n(rst_n), .scl(scl),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addrStrapLow(strapLo),
    .addrStrapHigh(strapHi), .shutdownPin_n(outA | ~selfMode), .logicOutFirst(outA),
    .logicOutSecond(outB), .shutdownActive(shutdown_pin_n), .wiperFirst(wipA), .wiperSecond(wipB));
  ////////////////////////////////////////
  task automatic note(input logic [7:0] e, input logic [7:0] a);
    expQ.push_back(e);
    obs = a;
    ->got;
    #1;
  endtask
  always @(got) begin
    head = expQ.pop_front();
    n_checks++;
    if (obs !== head) begin
      mismatches++;
      $display("[FAIL] %0t ns: saw %h, wanted %h", $time, obs, head);
    end
  end
  task automatic tx(input logic [7:0] b);
    bm.byte_io(b, 1'b1, rx, ack);
  endtask
  task automatic wi(input logic [7:0] ins);
    bm.start();
    tx(aW);
    note(8'h01, {7'h00, ack});
    tx(ins);
  endtask
  task automatic rd(input logic [7:0] e);
    bm.start();
    tx(aR);
    bm.byte_io(8'hff, 1'b1, rx, ack);
    bm.stop();
    note(e, rx);
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // A hung frame must not stall the run.
  initial begin
    #500000;
    mismatches++;
    give_verdict();
  end
  ////////////////////////////////////////
  initial begin
    selfMode = 1'b0;
    rnd = $random(seed);
    strapLo = rnd[0];
    strapHi = rnd[1];
    aW = {digipot_pkg::ADDR_FIXED, rnd[1], rnd[0], 1'b0};
    aR = aW | 8'h01;
    d0 = rnd[15:8];
    d1 = d0 ^ {1'h1, rnd[22:16]};
    d2 = d1 ^ {2'h1, rnd[29:24]};
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    note(8'h00, outs);
    $display("reset test done");
    wi(8'h08);
    tx(d0);
    note(d0, wipA);
    tx(d1);
    bm.stop();
    note(d1, wipA);
    note(8'h01, outs);
    wi(8'h90);
    tx(d2);
    bm.stop();
    note(d2, wipB);
    note(8'h02, outs);
    wi(8'h00);
    rd(d1);
    wi(8'h80);
    rd(d2);
    $display("readback test done");
    for (int k = 1; k < 3; k++) begin
      bm.start();
      tx(aW ^ (8'h01 << k));
      note(8'h00, {7'h00, ack});
      tx(8'h18);
      bm.stop();
    end
    note(8'h00, outs);
    wi(8'h00);
    tx(d0);
    wi(8'h18);
    bm.stop();
    note(8'h03, outs);
    note(d0, wipA);
    note(d2, wipB);
    $display("address and output test done");
    wi(8'h28);
    bm.stop();
    note(8'h01, {7'h00, shutdown_pin_n});
    wi(8'h28);
    tx(d1);
    bm.stop();
    note(d1, wipA);
    wi(8'h08);
    bm.stop();
    note(8'h00, {7'h00, shutdown_pin_n});
    note(d1, wipA);
    selfMode = 1'b1;
    wi(8'h00);
    bm.stop();
    repeat (8) @(posedge core_clk);
    note(8'h01, {7'h00, shutdown_pin_n});
    wi(8'h00);
    tx(d2);
    wi(8'h08);
    bm.stop();
    repeat (8) @(posedge core_clk);
    note(8'h00, {7'h00, shutdown_pin_n});
    note(d2, wipA);
    wi(8'hc8);
    tx(~digipot_pkg::WIPER_MID);
    bm.stop();
    note(digipot_pkg::WIPER_MID, wipB);
    $display("shutdown and midscale test done");
    give_verdict();
  end
endmodule
